// File: common/lsic_pkg.sv
// Shared constants and types of the light sensor control block.
package lsic_pkg;

  localparam logic [5:0] ADDR_PREFIX  = 6'h22;
  localparam logic [2:0] OFS_COMMAND  = 3'h0;
  localparam logic [2:0] OFS_CONTROL  = 3'h1;
  localparam logic [2:0] OFS_THR_HIGH = 3'h2;
  localparam logic [2:0] OFS_THR_LOW  = 3'h3;
  localparam logic [2:0] OFS_SNS_LOW  = 3'h4;
  localparam logic [2:0] OFS_SNS_HIGH = 3'h5;
  localparam logic [2:0] OFS_TMR_LOW  = 3'h6;
  localparam logic [2:0] OFS_TMR_HIGH = 3'h7;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [7:0] MASK_COMMAND = 8'hef;
  localparam logic [7:0] MASK_CONTROL = 8'h0c;

  // Field positions inside the command, control and address bytes.
  localparam int BIT_RUN       = 7;
  localparam int BIT_SLEEP     = 6;
  localparam int BIT_TIMING    = 5;
  localparam int BIT_PD_HI     = 3;
  localparam int BIT_PD_LO     = 2;
  localparam int BIT_WIDTH_HI  = 1;
  localparam int BIT_WIDTH_LO  = 0;
  localparam int BIT_RANGE_HI  = 3;
  localparam int BIT_ADDR_SYNC = 7;
  localparam int BIT_ADDR_CLR  = 6;

  localparam logic [1:0] PD_LIGHT = 2'h2;

  // Last count of an internally timed integration per width code.
  localparam logic [15:0] TERM_W0 = 16'hffff;
  localparam logic [15:0] TERM_W1 = 16'h0fff;
  localparam logic [15:0] TERM_W2 = 16'h00ff;
  localparam logic [15:0] TERM_W3 = 16'h000f;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  typedef enum logic [8:0] {
    LSIC_IDLE      = 9'h001,
    LSIC_ADDR      = 9'h002,
    LSIC_ADDR_ACK  = 9'h004,
    LSIC_REG       = 9'h008,
    LSIC_REG_ACK   = 9'h010,
    LSIC_WDATA     = 9'h020,
    LSIC_WDATA_ACK = 9'h040,
    LSIC_RDATA     = 9'h080,
    LSIC_RDATA_ACK = 9'h100
  } lsic_bus_state_t;

  // Converter settings carried into the oscillator domain.
  typedef struct packed {
    logic       run;
    logic       sleep;
    logic       timing;
    logic [1:0] pd_mode;
    logic [1:0] width;
    logic       slow;
  } lsic_cfg_t;

  // One finished integration.
  typedef struct packed {
    logic [15:0] sensor;
    logic [15:0] timer;
  } lsic_result_t;

  typedef struct packed {
    lsic_bus_state_t st;
    logic [3:0]      bits;
    logic [7:0]      shf;
    logic [2:0]      ptr;
    logic            rw;
    logic            ack;
    logic            scl_d;
    logic            sda_d;
    logic            sda_low;
    logic [7:0]      cmd;
    logic [7:0]      ctrl;
    logic [7:0]      thr_hi;
    logic [7:0]      thr_lo;
    lsic_result_t    res;
    logic            sync_tgl;
    logic            done_seen;
    logic            int_pend;
  } lsic_core_t;

  typedef struct packed {
    logic [15:0]  count;
    logic         phase;
    logic         sync_seen;
    logic         done_tgl;
    logic         integrating;
    lsic_result_t res;
  } lsic_osc_t;

endpackage : lsic_pkg

// File: logic/lsic_sync.sv
// Two flip-flop level synchroniser for a group of bits.
`timescale 1ns/1ns
module lsic_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end

  assign o_q = q_reg;

endmodule : lsic_sync

// File: logic/lsic_top.sv
// Serial register slave and integration control of the light sensor.
`timescale 1ns/1ns
module lsic_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_osc_clk,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  input  wire logic        i_address_pin_lsb,
  input  wire logic [15:0] i_adc_result,
  input  wire logic        i_int_event,
  output logic             o_converter_reset,
  output logic             o_converter_sleep,
  output logic             o_osc_slow,
  output logic             o_integrating,
  output logic             o_int_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release in both domains.

  logic [1:0] rst_core_reg;
  logic [1:0] rst_osc_reg;
  logic       rst_core_n;
  logic       rst_osc_n;

  // Assertion is immediate, release waits two edges of each clock.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_core_reg <= 2'h0;
    end else begin
      rst_core_reg <= {rst_core_reg[0], 1'b1};
    end
  end

  // The oscillator domain gets its own released copy.
  always_ff @(posedge i_osc_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_osc_reg <= 2'h0;
    end else begin
      rst_osc_reg <= {rst_osc_reg[0], 1'b1};
    end
  end

  assign rst_core_n = rst_core_reg[1];
  assign rst_osc_n  = rst_osc_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and domain crossings.

  lsic_pkg::lsic_core_t r_reg;
  lsic_pkg::lsic_core_t r_next;
  lsic_pkg::lsic_osc_t  q_reg;
  lsic_pkg::lsic_osc_t  q_next;
  lsic_pkg::lsic_cfg_t  cfg_core;
  lsic_pkg::lsic_cfg_t  cfg_osc;
  logic [2:0]           pins_s;
  logic                 scl_s;
  logic                 sda_s;
  logic                 apin_s;
  logic                 sync_s;
  logic                 done_s;

  lsic_sync #(.W(3)) u_pin_sync (
    .i_clk    (i_core_clk),
    .i_arst_n (rst_core_n),
    .i_d      ({i_scl, i_sda, i_address_pin_lsb}),
    .o_q      (pins_s)
  );

  assign scl_s  = pins_s[2];
  assign sda_s  = pins_s[1];
  assign apin_s = pins_s[0];

  // Settings change only on a register write, so a level crossing per bit
  // is enough; a torn value lasts one oscillator cycle at most.
  assign cfg_core.run     = r_reg.cmd[lsic_pkg::BIT_RUN];
  assign cfg_core.sleep   = r_reg.cmd[lsic_pkg::BIT_SLEEP];
  assign cfg_core.timing  = r_reg.cmd[lsic_pkg::BIT_TIMING];
  assign cfg_core.pd_mode = r_reg.cmd[lsic_pkg::BIT_PD_HI:lsic_pkg::BIT_PD_LO];
  assign cfg_core.width   =
    r_reg.cmd[lsic_pkg::BIT_WIDTH_HI:lsic_pkg::BIT_WIDTH_LO];
  assign cfg_core.slow    = ~r_reg.ctrl[lsic_pkg::BIT_RANGE_HI];

  lsic_sync #(.W($bits(lsic_pkg::lsic_cfg_t) + 1)) u_cfg_sync (
    .i_clk    (i_osc_clk),
    .i_arst_n (rst_osc_n),
    .i_d      ({cfg_core, r_reg.sync_tgl}),
    .o_q      ({cfg_osc, sync_s})
  );

  // Finished results cross by toggle; the data stand still meanwhile.
  lsic_sync #(.W(1)) u_done_sync (
    .i_clk    (i_core_clk),
    .i_arst_n (rst_core_n),
    .i_d      (q_reg.done_tgl),
    .o_q      (done_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read path.

  // Unmapped offsets read as zero.
  function automatic logic [7:0] rd_byte(input lsic_pkg::lsic_core_t s,
                                         input logic [2:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    if (ofs == lsic_pkg::OFS_COMMAND) begin
      v = s.cmd;
    end else if (ofs == lsic_pkg::OFS_CONTROL) begin
      v = s.ctrl;
    end else if (ofs == lsic_pkg::OFS_THR_HIGH) begin
      v = s.thr_hi;
    end else if (ofs == lsic_pkg::OFS_THR_LOW) begin
      v = s.thr_lo;
    end else if (ofs == lsic_pkg::OFS_SNS_LOW) begin
      v = s.res.sensor[7:0];
    end else if (ofs == lsic_pkg::OFS_SNS_HIGH) begin
      v = s.res.sensor[15:8];
    end else if (ofs == lsic_pkg::OFS_TMR_LOW) begin
      v = s.res.timer[7:0];
    end else if (ofs == lsic_pkg::OFS_TMR_HIGH) begin
      v = s.res.timer[15:8];
    end
    return v;
  endfunction : rd_byte

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: bus slave and register file.

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       clr_int;
  logic [7:0] rd_next;
  logic [2:0] ptr_inc;

  assign scl_rise  = scl_s & ~r_reg.scl_d;
  assign scl_fall  = ~scl_s & r_reg.scl_d;
  assign bus_start = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s;
  assign bus_stop  = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s;
  assign ptr_inc   = r_reg.ptr + 3'h1;
  assign rd_next   = rd_byte(r_reg, ptr_inc);

  // Bits move only on edges of the master's clock; the device never drives
  // the clock line, so stretching is not supported.
  always_comb begin
    r_next       = r_reg;
    clr_int      = 1'b0;
    r_next.scl_d = scl_s;
    r_next.sda_d = sda_s;
    if (done_s != r_reg.done_seen) begin
      r_next.done_seen = done_s;
      r_next.res       = q_reg.res;
    end
    if (bus_start) begin
      r_next.st      = lsic_pkg::LSIC_ADDR;
      r_next.bits    = 4'h0;
      r_next.sda_low = 1'b0;
    end else if (bus_stop) begin
      r_next.st      = lsic_pkg::LSIC_IDLE;
      r_next.sda_low = 1'b0;
    end else begin
      case (r_reg.st)
        lsic_pkg::LSIC_ADDR, lsic_pkg::LSIC_REG, lsic_pkg::LSIC_WDATA: begin
          if (scl_rise) begin
            r_next.shf  = {r_reg.shf[6:0], sda_s};
            r_next.bits = r_reg.bits + 4'h1;
          end else if (scl_fall && r_reg.bits == lsic_pkg::BITS_PER_BYTE) begin
            r_next.sda_low = 1'b1;
            if (r_reg.st == lsic_pkg::LSIC_ADDR) begin
              r_next.rw = r_reg.shf[0];
              r_next.st = lsic_pkg::LSIC_ADDR_ACK;
              if (r_reg.shf[7:1] != {lsic_pkg::ADDR_PREFIX, apin_s}) begin
                r_next.sda_low = 1'b0;
                r_next.st      = lsic_pkg::LSIC_IDLE;
              end
            end else if (r_reg.st == lsic_pkg::LSIC_REG) begin
              r_next.st  = lsic_pkg::LSIC_REG_ACK;
              r_next.ptr = r_reg.shf[2:0];
              if (r_reg.shf[lsic_pkg::BIT_ADDR_SYNC]) begin
                r_next.sync_tgl = ~r_reg.sync_tgl;
              end
              clr_int = r_reg.shf[lsic_pkg::BIT_ADDR_CLR];
            end else begin
              r_next.st  = lsic_pkg::LSIC_WDATA_ACK;
              r_next.ptr = ptr_inc;
              // Read-only offsets ignore writes; others keep until rewritten.
              if (r_reg.ptr == lsic_pkg::OFS_COMMAND) begin
                r_next.cmd = r_reg.shf & lsic_pkg::MASK_COMMAND;
              end else if (r_reg.ptr == lsic_pkg::OFS_CONTROL) begin
                r_next.ctrl = r_reg.shf & lsic_pkg::MASK_CONTROL;
              end else if (r_reg.ptr == lsic_pkg::OFS_THR_HIGH) begin
                r_next.thr_hi = r_reg.shf;
              end else if (r_reg.ptr == lsic_pkg::OFS_THR_LOW) begin
                r_next.thr_lo = r_reg.shf;
              end
            end
          end
        end
        lsic_pkg::LSIC_ADDR_ACK, lsic_pkg::LSIC_REG_ACK,
        lsic_pkg::LSIC_WDATA_ACK: begin
          if (scl_fall) begin
            r_next.bits    = 4'h0;
            r_next.sda_low = 1'b0;
            if (r_reg.st == lsic_pkg::LSIC_ADDR_ACK && r_reg.rw) begin
              r_next.shf     = rd_byte(r_reg, r_reg.ptr);
              r_next.sda_low = ~r_next.shf[7];
              r_next.st      = lsic_pkg::LSIC_RDATA;
            end else if (r_reg.st == lsic_pkg::LSIC_ADDR_ACK) begin
              r_next.st = lsic_pkg::LSIC_REG;
            end else begin
              r_next.st = lsic_pkg::LSIC_WDATA;
            end
          end
        end
        lsic_pkg::LSIC_RDATA: begin
          if (scl_rise) begin
            r_next.bits = r_reg.bits + 4'h1;
          end else if (scl_fall) begin
            if (r_reg.bits == lsic_pkg::BITS_PER_BYTE) begin
              r_next.sda_low = 1'b0;
              r_next.st      = lsic_pkg::LSIC_RDATA_ACK;
            end else begin
              r_next.shf     = {r_reg.shf[6:0], 1'b0};
              r_next.sda_low = ~r_reg.shf[6];
            end
          end
        end
        lsic_pkg::LSIC_RDATA_ACK: begin
          if (scl_rise) begin
            r_next.ack = ~sda_s;
          end else if (scl_fall) begin
            if (r_reg.ack) begin
              r_next.ptr     = ptr_inc;
              r_next.shf     = rd_next;
              r_next.sda_low = ~rd_next[7];
              r_next.bits    = 4'h0;
              r_next.st      = lsic_pkg::LSIC_RDATA;
            end else begin
              r_next.st = lsic_pkg::LSIC_IDLE;
            end
          end
        end
        default: begin
          r_next.sda_low = 1'b0;
        end
      endcase
    end
    // A new event in the clearing cycle keeps the flag set.
    if (clr_int) begin
      r_next.int_pend = 1'b0;
    end
    if (i_int_event) begin
      r_next.int_pend = 1'b1;
    end
  end

  // Settings come out of reset at zero; the bus state starts idle and the sampled pin levels start high.
  always_ff @(posedge i_core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      r_reg        <= '0;
      r_reg.st     <= lsic_pkg::LSIC_IDLE;
      r_reg.cmd    <= lsic_pkg::RESET_BYTE;
      r_reg.ctrl   <= lsic_pkg::RESET_BYTE;
      r_reg.thr_hi <= lsic_pkg::RESET_BYTE;
      r_reg.thr_lo <= lsic_pkg::RESET_BYTE;
      r_reg.scl_d  <= 1'b1;
      r_reg.sda_d  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator domain: integration timing.

  logic        active;
  logic        tick;
  logic        sync_ev;
  logic [15:0] term;

  // Only mode 1:0 converts; reset, sleep and the other modes stop it.
  assign active  = cfg_osc.run & ~cfg_osc.sleep &
                   (cfg_osc.pd_mode == lsic_pkg::PD_LIGHT);
  assign tick    = ~cfg_osc.slow | q_reg.phase;
  assign sync_ev = sync_s != q_reg.sync_seen;

  // Width code to the last count of an integration.
  always_comb begin
    case (cfg_osc.width)
      2'h0:    term = lsic_pkg::TERM_W0;
      2'h1:    term = lsic_pkg::TERM_W1;
      2'h2:    term = lsic_pkg::TERM_W2;
      default: term = lsic_pkg::TERM_W3;
    endcase
  end

  // A capture toggles done_tgl; results are held until the next capture.
  always_comb begin
    q_next             = q_reg;
    q_next.sync_seen   = sync_s;
    q_next.phase       = ~q_reg.phase;
    q_next.integrating = active;
    if (!active) begin
      q_next.count = 16'h0000;
    end else if (cfg_osc.timing) begin
      if (sync_ev) begin
        q_next.res.sensor = i_adc_result;
        q_next.res.timer  = q_reg.count;
        q_next.done_tgl   = ~q_reg.done_tgl;
        q_next.count      = 16'h0000;
      end else if (tick && q_reg.count != lsic_pkg::COUNT_MAX) begin
        q_next.count = q_reg.count + 16'h0001;
      end
    end else if (tick) begin
      if (q_reg.count == term) begin
        q_next.res.sensor = i_adc_result;
        q_next.done_tgl   = ~q_reg.done_tgl;
        q_next.count      = 16'h0000;
      end else begin
        q_next.count = q_reg.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_osc_clk or negedge rst_osc_n) begin
    if (!rst_osc_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Open-drain data line: only ever pulled low.
  assign o_sda_o           = 1'b0;
  assign o_sda_oe          = r_reg.sda_low;
  assign o_converter_reset = ~r_reg.cmd[lsic_pkg::BIT_RUN];
  assign o_converter_sleep = r_reg.cmd[lsic_pkg::BIT_SLEEP];
  assign o_osc_slow        = cfg_core.slow;
  assign o_integrating     = q_reg.integrating;
  assign o_int_pending     = r_reg.int_pend;

endmodule : lsic_top

// File: testbench/lsic_props.sv
// Concurrent checks on the pins of the light sensor control block.
`timescale 1ns/1ns
module lsic_props (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic i_int_event,
  input wire logic o_converter_reset,
  input wire logic o_converter_sleep,
  input wire logic o_osc_slow,
  input wire logic o_integrating,
  input wire logic o_int_pending
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  //////////////////////////////////////////////////////////////////////////
  // The pending flag follows an event and a clear never beats a set.
  int_set_a: assert property (i_int_event |-> ##[1:3] o_int_pending)
    else $error("pending flag missed an event");
  int_clear_a: assert property (
    $fell(o_int_pending) |-> !$past(i_int_event))
    else $error("pending flag cleared against an event");
  // The data pin only moves while the serial clock is low.
  oe_hold_a: assert property (
    i_scl && $past(i_scl) |-> $stable(o_sda_oe))
    else $error("data pin moved while clock high");
  oe_late_a: assert property ($fell(i_scl) |=> $stable(o_sda_oe))
    else $error("data pin answered before synchroniser delay");
  // The pin is only ever pulled low, and a pull begins with the clock low.
  sda_low_a: assert property (
    $rose(o_sda_oe) |-> !i_scl && !o_sda_o)
    else $error("data pin pulled while clock high");
  // Integration may only start with the converter released and awake.
  integ_gate_a: assert property ($rose(o_integrating)
    |-> !o_converter_reset && !o_converter_sleep)
    else $error("integration started while disabled");
  stop_integ_a: assert property ($rose(o_converter_reset) ||
    $rose(o_converter_sleep) |-> ##[1:40] !o_integrating)
    else $error("integration kept running when disabled");
  // Settings change only through a bus write, acted on with clock low.
  cfg_write_a: assert property ($changed(o_converter_reset) ||
    $changed(o_osc_slow) || $changed(o_converter_sleep) |-> !i_scl)
    else $error("setting changed outside a write");
  // Core outputs are checked one core edge into reset; the oscillator side,
  // reset at once as well, is only looked at six core edges in.
  rst_vals_a: assert property (disable iff (1'b0)
    !i_arst_n && !$past(i_arst_n) |->
    o_converter_reset && !o_converter_sleep && o_osc_slow &&
    !o_int_pending && !o_sda_oe)
    else $error("wrong value during reset");
  rst_integ_a: assert property (disable iff (1'b0)
    !i_arst_n && !$past(i_arst_n, 6) |-> !o_integrating)
    else $error("integration seen during reset");
  cov_int_c: cover property ($rose(o_integrating));
  cov_clr_c: cover property ($fell(o_int_pending));
  cov_ack_c: cover property ($rose(o_sda_oe));
endmodule : lsic_props

// File: testbench/lsic_master.sv
// Serial bus host model that clocks the sensor's register link.
`timescale 1ns/1ns
module lsic_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // The host alone drives the clock; a released data line reads high.
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Ten core clocks a phase keeps above the slave's eight-clock minimum.
  task automatic half();
    repeat (10) @(negedge i_clk);
  endtask : half
  // Start condition, also used as repeated start.
  task automatic start();
    o_sda = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b0;
    half();
    o_scl = 1'b0;
    half();
  endtask : start
  task automatic stop();
    o_sda = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b1;
    half();
  endtask : stop
  // Data held two clocks past the fall so the slave's sampler never races.
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    half();
    o_scl = 1'b1;
    half();
    r = i_sda;
    o_scl = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask : bitx
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask : rbyte
endmodule : lsic_master

// File: testbench/lsic_top_tb.sv
// Bench that drives the light sensor block as a serial host would.
`timescale 1ns/1ns
module lsic_top_tb;
  logic        clk, osc, rst_n, pin, int_ev, ack;
  logic [15:0] adc;
  logic [7:0]  rd_v;
  wire         scl, sda_m, sda_o, sda_oe, c_rst, c_slp, slow, integ, pend;
  wire         sda;
  int          failures, cmp_count, cycles;
  // Open-drain line with pull-up: low whenever anyone pulls it.
  assign sda = sda_oe ? 1'b0 : sda_m;
  lsic_top lsic_top_inst (.i_core_clk(clk), .i_arst_n(rst_n),
    .i_osc_clk(osc), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_address_pin_lsb(pin), .i_adc_result(adc),
    .i_int_event(int_ev), .o_converter_reset(c_rst),
    .o_converter_sleep(c_slp), .o_osc_slow(slow),
    .o_integrating(integ), .o_int_pending(pend));
  lsic_master lsic_master_inst (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda(sda_m));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #5;
    forever #16 osc = ~osc;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    lsic_master_inst.start();
    lsic_master_inst.wbyte(8'h88, ack);
    chk(16'(ack), 16'h1);
    lsic_master_inst.wbyte(ofs, ack);
    lsic_master_inst.wbyte(d, ack);
    lsic_master_inst.stop();
  endtask : wr
  // Pointer set by a write, then a repeated start reads one byte.
  task automatic rd(input logic [7:0] ofs);
    lsic_master_inst.start();
    lsic_master_inst.wbyte(8'h88, ack);
    lsic_master_inst.wbyte(ofs, ack);
    lsic_master_inst.start();
    lsic_master_inst.wbyte(8'h89, ack);
    lsic_master_inst.rbyte(1'b1, rd_v);
    lsic_master_inst.stop();
  endtask : rd
  task automatic rc(input logic [7:0] ofs, input logic [7:0] exp);
    rd(ofs);
    chk(16'(rd_v), 16'(exp));
  endtask : rc
  // A hung handshake is cut short and reported as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    pin = 1'b0;
    int_ev = 1'b0;
    adc = 16'h1234;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    for (int i = 0; i < 8; i++) rc(i[7:0], 8'h00);
    wr(8'h00, 8'hff);
    rc(8'h00, 8'hef);
    wr(8'h01, 8'hff);
    rc(8'h01, 8'h0c);
    chk(16'(slow), 16'h0);
    wr(8'h01, 8'h04);
    chk(16'(slow), 16'h1);
    wr(8'h01, 8'h0c);
    wr(8'h02, 8'ha5);
    wr(8'h03, 8'h5a);
    rc(8'h02, 8'ha5);
    rc(8'h03, 8'h5a);
    wr(8'h04, 8'hff);
    rc(8'h04, 8'h00);
    // Every photodiode pattern; only the light-count one integrates.
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 8'h83 | 8'(p << 2));
      repeat (40) @(negedge clk);
      chk(16'(integ), 16'(p == 2));
      chk(16'(c_rst), 16'h0);
    end
    rc(8'h04, 8'h34);
    rc(8'h05, 8'h12);
    rc(8'h06, 8'h00);
    // Run first, so that sleep has a live integration to stop.
    wr(8'h00, 8'h8b);
    repeat (40) @(negedge clk);
    chk(16'(integ), 16'h1);
    wr(8'h00, 8'hcb);
    repeat (40) @(negedge clk);
    chk(16'(c_slp), 16'h1);
    chk(16'(integ), 16'h0);
    wr(8'h00, 8'h8b);
    wr(8'h00, 8'h0b);
    repeat (40) @(negedge clk);
    chk(16'(c_rst), 16'h1);
    chk(16'(integ), 16'h0);
    // Width 1:0 needs 256 ticks, about 2048 core clocks, per result.
    adc = 16'h0f0f;
    wr(8'h00, 8'h8a);
    rc(8'h04, 8'h34);
    repeat (1400) @(negedge clk);
    rc(8'h04, 8'h0f);
    // Two host syncs one transfer apart, about 83 oscillator ticks.
    adc = 16'h5aa5;
    wr(8'h00, 8'hab);
    wr(8'h80, 8'hab);
    wr(8'h80, 8'hab);
    rc(8'h04, 8'ha5);
    rc(8'h05, 8'h5a);
    rc(8'h07, 8'h00);
    rd(8'h06);
    chk(16'(rd_v > 8'h46 && rd_v < 8'h64), 16'h1);
    @(negedge clk) int_ev = 1'b1;
    @(negedge clk) int_ev = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'(pend), 16'h1);
    // An event standing through the clear keeps the flag set.
    int_ev = 1'b1;
    wr(8'h41, 8'h0c);
    int_ev = 1'b0;
    chk(16'(pend), 16'h1);
    wr(8'h41, 8'h0c);
    chk(16'(pend), 16'h0);
    // Strap set to one: the old address is refused, the new one acked.
    pin = 1'b1;
    repeat (10) @(negedge clk);
    lsic_master_inst.start();
    lsic_master_inst.wbyte(8'h88, ack);
    lsic_master_inst.stop();
    chk(16'(ack), 16'h0);
    lsic_master_inst.start();
    lsic_master_inst.wbyte(8'h8a, ack);
    lsic_master_inst.stop();
    chk(16'(ack), 16'h1);
    end_of_test();
  end
endmodule : lsic_top_tb
bind lsic_top lsic_props lsic_props_inst (.i_core_clk(i_core_clk),
  .i_arst_n(i_arst_n), .i_scl(i_scl), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .i_int_event(i_int_event),
  .o_converter_reset(o_converter_reset),
  .o_converter_sleep(o_converter_sleep), .o_osc_slow(o_osc_slow),
  .o_integrating(o_integrating), .o_int_pending(o_int_pending));
